/* rtl/spcp_top.sv */
// spcp_top: ahb-lite register port for three secure-gated 16-pin ports
`timescale 1ns/100ps
`default_nettype none
module spcp_top (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic security_ext_on,
   input wire logic [1:0] fuse_init_bits,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hnonsec,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [spcp_pkg::NB-1:0] pin_level,
   input wire logic [spcp_pkg::NB-1:0] periph_secure,
   input wire logic [spcp_pkg::NB-1:0] periph_analog,
   input wire logic [spcp_pkg::NB-1:0] periph_out,
   output logic [spcp_pkg::NB-1:0] periph_to_pin,
   output logic [spcp_pkg::NB-1:0] pin_to_periph,
   output logic [spcp_pkg::NB-1:0] path_open,
   output logic [spcp_pkg::NPORT*32-1:0] pin_mode_field,
   output logic [spcp_pkg::NPORT*32-1:0] pin_slew_field,
   output logic [spcp_pkg::NPORT*32-1:0] pin_pull_field,
   output logic [spcp_pkg::NB-1:0] pin_drive_type_bit,
   output logic [spcp_pkg::NB-1:0] pin_output_level,
   output logic [spcp_pkg::NB-1:0] pin_secure_bit
);
   import spcp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // reset release and pin sampling

   logic rst_meta_reg, rst_n_reg;
   logic [NB-1:0] pin_sync;
   // async assert, release after two edges
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   spcp_sync2 #(.W(NB)) u_pin_sync (
      .clk(core_clk),
      .rst_n(rst_n_reg),
      .d(pin_level),
      .q(pin_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite address phase and bus state

   logic acc, in_sec, in_ns, a_hit, a_secure;
   logic [1:0] a_port;
   logic [NPORT*32-1:0] rd_all;
   logic init_done_reg, init_done_next;
   logic wr_reg, wr_next;
   logic wsec_reg, wsec_next;
   logic [1:0] wport_reg, wport_next;
   logic [9:0] woff_reg, woff_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic hready_reg, hready_next;
   logic hresp_reg;

   // alias decode, one 0x400 window per port
   always_comb begin
      acc = hsel & hready & htrans[1];
      in_sec = haddr[31:PAGE_LSB] == SEC_BASE[31:PAGE_LSB];
      in_ns = haddr[31:PAGE_LSB] == NSEC_BASE[31:PAGE_LSB];
      a_port = haddr[PAGE_LSB-1:PORT_LSB];
      a_hit = acc & (in_sec | in_ns) & (a_port < PORT_CNT) & (hsize == SIZE_WORD);
      // without the extension there is nothing to hide
      a_secure = ~security_ext_on | (in_sec & ~hnonsec);
   end

   // next state of the bus side; writes land one cycle after the address phase
   always_comb begin
      init_done_next = 1'b1;
      hready_next = init_done_reg;
      wr_next = a_hit & hwrite;
      wsec_next = a_secure;
      wport_next = a_port;
      woff_next = haddr[PORT_LSB-1:0];
      hrdata_next = '0;
      if (a_hit && !hwrite) begin
         hrdata_next = rd_all[a_port*32 +: 32];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         init_done_reg <= 1'b0;
         hready_reg <= 1'b0;
         hresp_reg <= 1'b0;
         wr_reg <= 1'b0;
         wsec_reg <= 1'b0;
         wport_reg <= 2'h0;
         woff_reg <= 10'h000;
         hrdata_reg <= 32'h0000_0000;
      end else begin
         init_done_reg <= init_done_next;
         hready_reg <= hready_next;
         hresp_reg <= 1'b0;
         wr_reg <= wr_next;
         wsec_reg <= wsec_next;
         wport_reg <= wport_next;
         woff_reg <= woff_next;
         hrdata_reg <= hrdata_next;
      end
   end

   assign hreadyout = hready_reg;
   assign hresp = hresp_reg;
   assign hrdata = hrdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // per-port register banks

   for (genvar p = 0; p < NPORT; p++) begin : g_port
      logic [31:0] mode_reg, mode_next, slew_reg, slew_next, pull_reg, pull_next;
      logic [15:0] drv_reg, drv_next, out_reg, out_next, sec_reg, sec_next;
      logic [15:0] wm1, rm1, inlv;
      logic [31:0] wm2, rm2, rv;

      // read view; secure pins masked for non-secure readers in every word except the secure config word
      always_comb begin
         rm1 = a_secure ? SEC_ALL : ~sec_reg;
         for (int i = 0; i < NPIN; i++) begin
            rm2[2*i +: 2] = {2{rm1[i]}};
            // analog pins read their input level as zero
            inlv[i] = pin_sync[p*NPIN+i] & (mode_reg[2*i +: 2] != MODE_ANALOG);
         end
         unique case (haddr[PORT_LSB-1:0])
            OFS_MODE: rv = mode_reg & rm2;
            OFS_DRIVE: rv = {16'h0000, drv_reg & rm1};
            OFS_SLEW: rv = slew_reg & rm2;
            OFS_PULL: rv = pull_reg & rm2;
            OFS_INLV: rv = {16'h0000, inlv & rm1};
            OFS_OUTLV: rv = {16'h0000, out_reg & rm1};
            OFS_SECCFG: rv = {16'h0000, sec_reg};
            default: rv = 32'h0000_0000;
         endcase
      end
      assign rd_all[p*32 +: 32] = rv;

      // write merge keeps secure pins' bits for non-secure writers
      always_comb begin
         wm1 = wsec_reg ? SEC_ALL : ~sec_reg;
         for (int i = 0; i < NPIN; i++) begin
            wm2[2*i +: 2] = {2{wm1[i]}};
         end
         mode_next = mode_reg;
         slew_next = slew_reg;
         pull_next = pull_reg;
         drv_next = drv_reg;
         out_next = out_reg;
         sec_next = sec_reg;
         if (!init_done_reg) begin
            // fuse levels are taken once, on the first edge after release
            mode_next = MODE_RST[p][fuse_init_bits];
            slew_next = SLEW_RST[p][fuse_init_bits];
            pull_next = PULL_RST[p][fuse_init_bits];
            drv_next = DRIVE_RST;
            out_next = OUTLV_RST;
            sec_next = security_ext_on ? SEC_ALL : 16'h0000;
         end else if (wr_reg && wport_reg == 2'(p)) begin
            unique case (woff_reg)
               OFS_MODE: mode_next = (mode_reg & ~wm2) | (hwdata & wm2);
               OFS_DRIVE: drv_next = (drv_reg & ~wm1) | (hwdata[15:0] & wm1);
               OFS_SLEW: slew_next = (slew_reg & ~wm2) | (hwdata & wm2);
               // 11 in a pull field is reserved and stored as written
               OFS_PULL: pull_next = (pull_reg & ~wm2) | (hwdata & wm2);
               OFS_OUTLV: out_next = (out_reg & ~wm1) | (hwdata[15:0] & wm1);
               // set applied after clear, so set wins on the same pin
               OFS_SETCLR: out_next = (out_reg & ~(hwdata[31:16] & wm1))
                                    | (hwdata[15:0] & wm1);
               OFS_SECCFG: begin
                  if (wsec_reg && security_ext_on) begin
                     sec_next = hwdata[15:0];
                  end
               end
               default: begin
                  mode_next = mode_reg;
               end
            endcase
         end
      end

      // reset constants are overwritten by the fuse load one edge later
      always_ff @(posedge core_clk or negedge rst_n_reg) begin
         if (!rst_n_reg) begin
            mode_reg <= 32'h0000_0000;
            slew_reg <= 32'h0000_0000;
            pull_reg <= 32'h0000_0000;
            drv_reg <= DRIVE_RST;
            out_reg <= OUTLV_RST;
            sec_reg <= SEC_ALL;
         end else begin
            mode_reg <= mode_next;
            slew_reg <= slew_next;
            pull_reg <= pull_next;
            drv_reg <= drv_next;
            out_reg <= out_next;
            sec_reg <= sec_next;
         end
      end

      assign pin_mode_field[p*32 +: 32] = mode_reg;
      assign pin_slew_field[p*32 +: 32] = slew_reg;
      assign pin_pull_field[p*32 +: 32] = pull_reg;
      assign pin_drive_type_bit[p*NPIN +: NPIN] = drv_reg;
      assign pin_output_level[p*NPIN +: NPIN] = out_reg;
      assign pin_secure_bit[p*NPIN +: NPIN] = sec_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // peripheral routing check

   spcp_pin_gate #(.W(NB)) u_gate (
      .clk(core_clk),
      .rst_n(rst_n_reg),
      .pin_secure(pin_secure_bit),
      .periph_secure(periph_secure),
      .periph_analog(periph_analog),
      .periph_out(periph_out),
      .pin_in(pin_sync),
      .to_pin(periph_to_pin),
      .to_periph(pin_to_periph),
      .path_open(path_open)
   );
endmodule
`default_nettype wire

/* rtl/spcp_pkg.sv */
// spcp_pkg: map, field codes and reset patterns of the secure pin port
package spcp_pkg;
   localparam int NPORT = 3;
   localparam int NPIN = 16;
   localparam int NB = NPORT * NPIN;
   localparam logic [1:0] PORT_CNT = 2'h3;
   localparam logic [31:0] SEC_BASE = 32'h5002_0000;
   localparam logic [31:0] NSEC_BASE = 32'h4002_0000;
   localparam logic [31:0] PORT_STEP = 32'h0000_0400;
   localparam int PAGE_LSB = 12;
   localparam int PORT_LSB = 10;
   localparam logic [2:0] SIZE_WORD = 3'h2;
   // register offsets inside one port
   localparam logic [9:0] OFS_MODE = 10'h000;
   localparam logic [9:0] OFS_DRIVE = 10'h004;
   localparam logic [9:0] OFS_SLEW = 10'h008;
   localparam logic [9:0] OFS_PULL = 10'h00C;
   localparam logic [9:0] OFS_INLV = 10'h010;
   localparam logic [9:0] OFS_OUTLV = 10'h014;
   localparam logic [9:0] OFS_SETCLR = 10'h018;
   localparam logic [9:0] OFS_SECCFG = 10'h030;
   // field codes
   localparam logic [1:0] MODE_INPUT = 2'h0;
   localparam logic [1:0] MODE_OUTPUT = 2'h1;
   localparam logic [1:0] MODE_ALT = 2'h2;
   localparam logic [1:0] MODE_ANALOG = 2'h3;
   localparam logic [1:0] PULL_NONE = 2'h0;
   localparam logic [1:0] PULL_UP = 2'h1;
   localparam logic [1:0] PULL_DOWN = 2'h2;
   localparam logic [15:0] DRIVE_RST = 16'h0000;
   localparam logic [15:0] OUTLV_RST = 16'h0000;
   localparam logic [15:0] SEC_ALL = 16'hFFFF;
   // reset patterns, [port][fuse_init_bits]
   localparam logic [31:0] MODE_RST [NPORT][4] = '{
      '{32'hA800_0000, 32'hA800_AA00, 32'hAAA8_0000, 32'hAAA8_AA00},
      '{32'h0000_0280, 32'h0000_0280, 32'h0000_0280, 32'h0000_0280},
      '{32'h0000_0000, 32'h0000_0000, 32'h0000_0A00, 32'h0000_0A00}};
   localparam logic [31:0] SLEW_RST [NPORT][4] = '{
      '{32'h0C00_0000, 32'h0C00_FF00, 32'h0FFC_0000, 32'h0FFC_FF00},
      '{32'h0000_00C0, 32'h0000_03C0, 32'h0000_00C0, 32'h0000_03C0},
      '{32'h0000_0000, 32'h0000_0000, 32'h0000_0F00, 32'h0000_0F00}};
   localparam logic [31:0] PULL_RST [NPORT][4] = '{
      '{32'h6400_0000, 32'h6400_A000, 32'h6680_0000, 32'h6680_A000},
      '{32'h0000_0100, 32'h0000_0280, 32'h0000_0100, 32'h0000_0280},
      '{32'h0000_0000, 32'h0000_0000, 32'h0000_0A00, 32'h0000_0A00}};
endpackage

/* rtl/spcp_sync2.sv */
// spcp_sync2: two-flop synchroniser for pin levels
`timescale 1ns/100ps
`default_nettype none
module spcp_sync2 #(
   parameter int W = 48
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;
   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         q_reg <= '0;
      end else begin
         meta_reg <= d;
         q_reg <= meta_reg;
      end
   end
   assign q = q_reg;
endmodule
`default_nettype wire

/* rtl/spcp_pin_gate.sv */
// spcp_pin_gate: security check on the peripheral-to-pin routing
`timescale 1ns/100ps
`default_nettype none
module spcp_pin_gate #(
   parameter int W = 48
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] pin_secure,
   input wire logic [W-1:0] periph_secure,
   input wire logic [W-1:0] periph_analog,
   input wire logic [W-1:0] periph_out,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] to_pin,
   output logic [W-1:0] to_periph,
   output logic [W-1:0] path_open
);
   logic [W-1:0] open_c;
   logic [W-1:0] to_pin_reg, to_pin_next;
   logic [W-1:0] to_per_reg, to_per_next;
   logic [W-1:0] open_reg;
   // digital: only secure-peripheral on open pin is refused; analog needs equal states
   always_comb begin
      open_c = (periph_analog & ~(pin_secure ^ periph_secure))
             | (~periph_analog & (~periph_secure | pin_secure));
      to_pin_next = periph_out & open_c;
      to_per_next = pin_in & open_c;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         to_pin_reg <= '0;
         to_per_reg <= '0;
         open_reg <= '0;
      end else begin
         to_pin_reg <= to_pin_next;
         to_per_reg <= to_per_next;
         open_reg <= open_c;
      end
   end
   assign to_pin = to_pin_reg;
   assign to_periph = to_per_reg;
   assign path_open = open_reg;
endmodule
`default_nettype wire

/* tb/spcp_top_chk.sv */
// spcp_top_chk: bus and routing assertions for the secure pin port
`timescale 1ns/100ps
`default_nettype none
module spcp_top_chk (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic security_ext_on,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hnonsec,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [spcp_pkg::NB-1:0] periph_secure,
   input wire logic [spcp_pkg::NB-1:0] periph_analog,
   input wire logic [spcp_pkg::NB-1:0] periph_out,
   input wire logic [spcp_pkg::NB-1:0] periph_to_pin,
   input wire logic [spcp_pkg::NB-1:0] pin_to_periph,
   input wire logic [spcp_pkg::NB-1:0] path_open,
   input wire logic [spcp_pkg::NB-1:0] pin_secure_bit
);
   import spcp_pkg::*;
   logic [3:0] age_reg;
   logic [3:0] age_next;
   logic [NB-1:0] open_exp;
   logic rd_any;
   logic rd_ns_a;
   logic cfg_wr;
   // edges since reset release; the internal copy lags, so checks wait
   always_comb begin
      age_next = (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         age_reg <= 4'h0;
      end else begin
         age_reg <= age_next;
      end
   end
   // route permission and qualified address phases
   assign open_exp = (periph_analog & ~(pin_secure_bit ^ periph_secure))
      | (~periph_analog & (~periph_secure | pin_secure_bit));
   assign rd_any = hsel & hready & htrans[1] & ~hwrite;
   assign rd_ns_a = rd_any & (hnonsec | haddr[31:12] == 20'h40020) & haddr[11:0] == 12'h004;
   assign cfg_wr = hsel & hready & htrans[1] & hwrite & ~hnonsec & security_ext_on
      & haddr[31:12] == 20'h50020 & haddr[9:0] == OFS_SECCFG;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   a_resp_okay: assert property (age_reg > 4'h5 |-> hresp == 1'b0 && hreadyout)
      else $error("bus answer not okay");
   a_rdata_idle: assert property (age_reg > 4'h2 && !$past(rd_any) |-> hrdata == 32'h0)
      else $error("read data outside read");
   a_secure_boot: assert property (age_reg == 4'h5 && security_ext_on |-> &pin_secure_bit)
      else $error("pins not secure after reset");
   a_route_perm: assert property (age_reg > 4'h4 |-> path_open == $past(open_exp))
      else $error("route permission wrong");
   a_pin_gate: assert property (age_reg > 4'h4 |-> periph_to_pin == $past(periph_out & open_exp))
      else $error("peripheral output leaks");
   a_periph_gate: assert property ((pin_to_periph & ~path_open) == '0)
      else $error("pin level leaks");
   a_cfg_guard: assert property (age_reg > 4'h5 && $changed(pin_secure_bit) |-> $past(cfg_wr, 2))
      else $error("secure cfg changed without secure write");
   a_ns_mask: assert property (rd_ns_a |=> (hrdata[15:0] & pin_secure_bit[15:0]) == 16'h0)
      else $error("secure pin visible to non-secure read");
endmodule
bind spcp_top spcp_top_chk spcp_top_chk_inst (.core_clk(core_clk), .rstn(rstn),
   .security_ext_on(security_ext_on), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hnonsec(hnonsec), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .periph_secure(periph_secure), .periph_analog(periph_analog),
   .periph_out(periph_out), .periph_to_pin(periph_to_pin), .pin_to_periph(pin_to_periph),
   .path_open(path_open), .pin_secure_bit(pin_secure_bit));
`default_nettype wire

/* tb/tb.sv */
// tb: self-checking bench for the secure pin port
`timescale 1ns/100ps
`default_nettype none
module tb;
   import spcp_pkg::*;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic security_ext_on = 1'b1;
   logic [1:0] fuse_init_bits = 2'h0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = SIZE_WORD;
   logic [31:0] hwdata = 32'h0;
   logic hnonsec = 1'b0;
   logic hreadyout, hresp;
   logic [31:0] hrdata;
   logic [NB-1:0] pin_level = '0, periph_secure = '0, periph_analog = '0, periph_out = '0;
   logic [NB-1:0] periph_to_pin, pin_to_periph, path_open, drv_o, lvl_o, pin_secure_bit;
   logic [NPORT*32-1:0] mode_o, slew_o, pull_o;
   logic [15:0] sec_m [NPORT];
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;
   ////////////////////////////////////////////////////////////////
   // clock and hang guard
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         close_out();
      end
   end
   spcp_top spcp_top_inst (.core_clk(core_clk), .rstn(rstn), .security_ext_on(security_ext_on),
      .fuse_init_bits(fuse_init_bits), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hnonsec(hnonsec),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_level(pin_level),
      .periph_secure(periph_secure), .periph_analog(periph_analog), .periph_out(periph_out),
      .periph_to_pin(periph_to_pin), .pin_to_periph(pin_to_periph), .path_open(path_open),
      .pin_mode_field(mode_o), .pin_slew_field(slew_o), .pin_pull_field(pull_o),
      .pin_drive_type_bit(drv_o), .pin_output_level(lvl_o), .pin_secure_bit(pin_secure_bit));
   ////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic cmp_vec(input logic [NB-1:0] got, input logic [NB-1:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // one single transfer; an idle cycle ahead keeps reads clear of a landing write
   task automatic xfer(input logic [31:0] a, input logic w, input logic ns, input logic [31:0] wd,
         output logic [31:0] rd);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hnonsec <= ns;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic do_reset(input logic [1:0] f);
      @(posedge core_clk);
      rstn <= 1'b0;
      fuse_init_bits <= f;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (6) @(posedge core_clk);
   endtask
   function automatic logic [31:0] adr(input logic s, input int p, input logic [9:0] o);
      return (s ? SEC_BASE : NSEC_BASE) + PORT_STEP * p + {22'h0, o};
   endfunction
   // bits of the secure pins, two per pin for the field registers
   function automatic logic [31:0] smask(input logic [15:0] s, input logic two);
      logic [31:0] m;
      m = 32'h0;
      for (int i = 0; i < 16; i++) begin
         if (two) m[2*i+:2] = {2{s[i]}};
         else m[i] = s[i];
      end
      return m;
   endfunction
   function automatic logic [NB-1:0] route_exp(input logic [NB-1:0] an, s, pv);
      return (an & ~(pv ^ s)) | (~an & (~s | pv));
   endfunction
   ////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [31:0] rd, d, e, m, mg;
      logic [NB-1:0] ox;
      logic [9:0] ofs [4];
      ofs = '{OFS_MODE, OFS_DRIVE, OFS_SLEW, OFS_PULL};
      void'($urandom(32'hf6ed30b6));
      for (int f = 0; f < 4; f++) begin
         do_reset(f[1:0]);
         cmp_vec(pin_secure_bit, '1, "secure boot");
         for (int p = 0; p < NPORT; p++) begin
            xfer(adr(1'b1, p, OFS_MODE), 1'b0, 1'b0, 32'h0, rd);
            cmp_word(rd, MODE_RST[p][f], "mode reset");
            xfer(adr(1'b1, p, OFS_SLEW), 1'b0, 1'b0, 32'h0, rd);
            cmp_word(rd, SLEW_RST[p][f], "slew reset");
            xfer(adr(1'b1, p, OFS_DRIVE), 1'b0, 1'b0, 32'h0, rd);
            cmp_word(rd, 32'h0000_0000, "drive reset");
         end
      end
      for (int p = 0; p < NPORT; p++) begin
         sec_m[p] = (p == 0) ? 16'h8001 : 16'($urandom);
         xfer(adr(1'b1, p, OFS_SECCFG), 1'b1, 1'b0, {16'h0, sec_m[p]}, rd);
         xfer(adr(1'b0, p, OFS_SECCFG), 1'b1, 1'b0, 32'h0, rd);
         xfer(adr(1'b1, p, OFS_SECCFG), 1'b1, 1'b1, 32'h0, rd);
         xfer(adr(1'b0, p, OFS_SECCFG), 1'b0, 1'b0, 32'h0, rd);
         cmp_word(rd, {16'h0, sec_m[p]}, "secure cfg");
         for (int r = 0; r < 4; r++) begin
            d = (r == 3) ? 32'hE4E4_E4E4 : $urandom;
            e = $urandom;
            // software keeps the upper half of the drive-type word at zero
            if (r == 1) begin
               d[31:16] = 16'h0;
               e[31:16] = 16'h0;
            end
            m = smask(sec_m[p], r != 1);
            mg = (d & m) | (e & ~m);
            if (r == 1) mg[31:16] = 16'h0;
            xfer(adr(1'b1, p, ofs[r]), 1'b1, 1'b0, d, rd);
            xfer(adr(1'b0, p, ofs[r]), 1'b1, 1'b0, e, rd);
            xfer(adr(1'b0, p, ofs[r]), 1'b0, 1'b0, 32'h0, rd);
            cmp_word(rd, mg & ~m, "non-secure view");
            xfer(adr(1'b1, p, ofs[r]), 1'b0, 1'b0, 32'h0, rd);
            cmp_word(rd, mg, "secure view");
            e = (r == 0) ? mode_o[p*32 +: 32] : (r == 2) ? slew_o[p*32 +: 32]
               : (r == 3) ? pull_o[p*32 +: 32] : {16'h0, drv_o[p*16 +: 16]};
            cmp_word(e, mg, "field outputs");
         end
      end
      xfer(adr(1'b1, 3, OFS_MODE), 1'b0, 1'b0, 32'h0, rd);
      cmp_word(rd, 32'h0, "unmapped port");
      // random peripheral routing against the secure map written above
      for (int k = 0; k < 30; k++) begin
         @(posedge core_clk);
         periph_secure <= NB'({$urandom, $urandom});
         periph_analog <= NB'({$urandom, $urandom});
         periph_out <= NB'({$urandom, $urandom});
         pin_level <= NB'({$urandom, $urandom});
         // pin path needs two sync edges plus the gate register
         repeat (4) @(posedge core_clk);
         ox = route_exp(periph_analog, periph_secure, {sec_m[2], sec_m[1], sec_m[0]});
         cmp_vec(path_open, ox, "route");
         cmp_vec(periph_to_pin, periph_out & ox, "to pin");
         cmp_vec(pin_to_periph, pin_level & ox, "to periph");
      end
      // output level, set/clear, and a non-secure set on secure pin 15
      xfer(adr(1'b1, 0, OFS_OUTLV), 1'b1, 1'b0, 32'h0000_00FF, rd);
      xfer(adr(1'b1, 0, OFS_SETCLR), 1'b1, 1'b0, 32'h000F_0F00, rd);
      xfer(adr(1'b0, 0, OFS_SETCLR), 1'b1, 1'b0, 32'h0000_8000, rd);
      xfer(adr(1'b1, 0, OFS_OUTLV), 1'b0, 1'b0, 32'h0, rd);
      cmp_word(rd, 32'h0000_0FF0, "set clear");
      cmp_word({16'h0, lvl_o[15:0]}, 32'h0000_0FF0, "output level");
      close_out();
   end
endmodule
`default_nettype wire
